/* File: hdl/pmon_pkg.sv */
// Shared constants, register map and field layout of the channel monitoring box
package pmon_pkg;
   // Structure
   localparam int NUM_CTR = 5;
   localparam int NUM_GEN = 4;
   localparam int CNT_W = 48;
   localparam int INC_W = 8;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_BOX_STATUS = 8'hf8;
   localparam logic [7:0] OFS_BOX_CTL = 8'hf4;
   localparam logic [7:0] OFS_FIXED_CTL = 8'hf0;
   localparam logic [7:0] OFS_CTL0 = 8'hd8;
   localparam logic [7:0] OFS_FIXED_CTR = 8'hd0;
   localparam logic [7:0] OFS_CTR0 = 8'ha0;
   localparam logic [7:0] CTL_STEP = 8'h04;
   localparam logic [7:0] CTR_STEP = 8'h08;
   localparam logic [7:0] CTR_HI_STEP = 8'h04;
   // Box control fields
   localparam int BOX_FRZ_BIT = 8;
   localparam int BOX_RST_CTRS_BIT = 1;
   localparam int BOX_RST_CTRL_BIT = 0;
   // Counter control fields
   localparam int CTL_EN_BIT = 22;
   localparam int CTL_WRAP_BIT = 20;
   localparam int CTL_EDGE_BIT = 18;
   localparam int CTL_RST_BIT = 17;
   localparam int FIXED_RST_BIT = 19;
   localparam int THRESH_LSB = 24;
   localparam int UMASK_LSB = 8;
   localparam int EVSEL_LSB = 0;
   localparam int FIELD_W = 8;
   // Storable bits; reserved and action bits read back as zero
   localparam logic [31:0] CTL_KEEP_MASK = 32'hff54ffff;
   localparam logic [31:0] FIXED_KEEP_MASK = 32'h00500000;
   localparam logic [31:0] CTL_RESET = 32'h00000000;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   localparam logic [31:0] RDATA_RESET = 32'h00000000;

   // Slot 0 is the fixed counter, slots 1..4 are generic counters 0..3
   function automatic logic [7:0] ctl_addr(input int slot);
      if (slot == 0) begin
         return OFS_FIXED_CTL;
      end
      return OFS_CTL0 + CTL_STEP * 8'(slot - 1);
   endfunction : ctl_addr

   function automatic logic [7:0] ctr_addr(input int slot);
      if (slot == 0) begin
         return OFS_FIXED_CTR;
      end
      return OFS_CTR0 + CTR_STEP * 8'(slot - 1);
   endfunction : ctr_addr
endpackage : pmon_pkg

/* File: hdl/event_shaper.sv */
// Threshold compare and edge detect applied to one counter's raw increment
module event_shaper (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Raw event and shaping controls
   input wire logic [pmon_pkg::INC_W-1:0] raw_inc,
   input wire logic [pmon_pkg::FIELD_W-1:0] thresh,
   input wire logic edge_on,
   // Shaped increment for the accumulator
   output logic [pmon_pkg::INC_W-1:0] inc
);
   import pmon_pkg::*;

   typedef struct packed {
      logic prev_hit;
   } shaper_state_t;

   shaper_state_t state_reg;
   shaper_state_t state_next;
   logic hit;

   // Edge detect follows the threshold, so it sees the qualified level only
   always_comb begin
      state_next = state_reg;
      hit = (raw_inc >= thresh);
      state_next.prev_hit = hit;
      if (thresh == '0) begin
         inc = raw_inc;
      end else if (edge_on) begin
         inc = INC_W'(hit && !state_reg.prev_hit);
      end else begin
         inc = INC_W'(hit);
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule : event_shaper

/* File: hdl/wrap_counter.sv */
// One 48-bit event accumulator with clear, word preload and carry-out detect
module wrap_counter (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Counting
   input wire logic count_en,
   input wire logic [pmon_pkg::INC_W-1:0] inc,
   // Software access
   input wire logic clr,
   input wire logic load_lo,
   input wire logic load_hi,
   input wire logic [pmon_pkg::DATA_W-1:0] wdata,
   // State out
   output logic [pmon_pkg::CNT_W-1:0] count,
   output logic wrap
);
   import pmon_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] count;
   } cnt_state_t;

   cnt_state_t state_reg;
   cnt_state_t state_next;
   logic [CNT_W:0] sum;

   // Clear beats preload beats counting; a wrap keeps the low bits and goes on
   always_comb begin
      state_next = state_reg;
      wrap = 1'b0;
      sum = {1'b0, state_reg.count} + (CNT_W + 1)'(inc);
      if (clr) begin
         state_next.count = '0;
      end else if (load_lo) begin
         state_next.count[DATA_W-1:0] = wdata;
      end else if (load_hi) begin
         state_next.count[CNT_W-1:DATA_W] = wdata[CNT_W-DATA_W-1:0];
      end else if (count_en) begin
         state_next.count = sum[CNT_W-1:0];
         wrap = sum[CNT_W];
      end
   end

   assign count = state_reg.count;

   // State register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule : wrap_counter

/* File: hdl/chan_pmon_box.sv */
// Monitoring box of one memory channel: box control, status and five counters
// Function
// - Freeze bit stops every counter in box
// - Clear-all-counts bit zeroes every counter
// - Clear-all-selects bit zeroes every control register
// - Five status flags, bit 0 is fixed
// - Flags clear only by writing one
// - Control bits 7:0 choose counted event
// - Control bits 15:8 choose counted subevents
// - Control bits 31:24 hold increment threshold
// - Reported wrap sets flag and messages monitor
// - Edge detect counts rising qualified transitions
// - Edge detect needs a non-zero threshold
// - Counter-clear bit zeroes its counter
// - Count only when enabled and unfrozen
// - 48-bit counter, wrap is carry from 47
// - Counter wraps and keeps counting
// - Fixed counter counts every DRAM clock
module chan_pmon_box (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Configuration access
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [pmon_pkg::ADDR_W-1:0] cfg_addr,
   input wire logic [pmon_pkg::DATA_W-1:0] cfg_wdata,
   output logic [pmon_pkg::DATA_W-1:0] cfg_rdata,
   output logic cfg_rvalid,
   // Event sources
   input wire logic dclk_tick,
   input wire logic [pmon_pkg::NUM_GEN-1:0][pmon_pkg::INC_W-1:0] event_inc,
   output logic [pmon_pkg::NUM_GEN-1:0][pmon_pkg::FIELD_W-1:0] event_choice,
   output logic [pmon_pkg::NUM_GEN-1:0][pmon_pkg::FIELD_W-1:0] subevent_mask,
   // Global monitor side
   output logic global_monitor_unit_wrap,
   output logic box_frozen
);
   import pmon_pkg::*;

   typedef struct packed {
      logic [NUM_CTR-1:0][DATA_W-1:0] ctl;
      logic [NUM_CTR-1:0] wrap_flags;
      logic frozen;
      logic [DATA_W-1:0] rdata;
      logic rvalid;
      logic msg;
   } box_state_t;

   box_state_t state_reg;
   box_state_t state_next;

   logic wr_box;
   logic wr_stat;
   logic [NUM_CTR-1:0] wr_ctl;
   logic [NUM_CTR-1:0] wr_lo;
   logic [NUM_CTR-1:0] wr_hi;
   logic [NUM_CTR-1:0] ctr_clr;
   logic [NUM_CTR-1:0] ctr_en;
   logic [NUM_CTR-1:0] wrap;
   logic [NUM_CTR-1:0] flag_set;
   logic [NUM_CTR-1:0][INC_W-1:0] raw_inc;
   logic [NUM_CTR-1:0][INC_W-1:0] shaped;
   logic [NUM_CTR-1:0][FIELD_W-1:0] thresh;
   logic [NUM_CTR-1:0] edge_on;
   logic [NUM_CTR-1:0][CNT_W-1:0] count;
   logic [DATA_W-1:0] rd_val;
   logic box_clr_ctrs;
   logic box_clr_ctls;

   // Box-wide decode; action bits act only when written with one
   assign wr_box = cfg_wr && (cfg_addr == OFS_BOX_CTL);
   assign wr_stat = cfg_wr && (cfg_addr == OFS_BOX_STATUS);
   assign box_clr_ctrs = wr_box && cfg_wdata[BOX_RST_CTRS_BIT];
   assign box_clr_ctls = wr_box && cfg_wdata[BOX_RST_CTRL_BIT];

   // One shaper and accumulator per slot; slot 0 is the fixed DRAM clock counter
   for (genvar i = 0; i < NUM_CTR; i++) begin : g_slot
      localparam int RST_BIT = (i == 0) ? FIXED_RST_BIT : CTL_RST_BIT;
      assign wr_ctl[i] = cfg_wr && (cfg_addr == ctl_addr(i));
      assign wr_lo[i] = cfg_wr && (cfg_addr == ctr_addr(i));
      assign wr_hi[i] = cfg_wr && (cfg_addr == ctr_addr(i) + CTR_HI_STEP);
      assign ctr_clr[i] = box_clr_ctrs || (wr_ctl[i] && cfg_wdata[RST_BIT]);
      assign ctr_en[i] = state_reg.ctl[i][CTL_EN_BIT] && !state_reg.frozen;
      assign flag_set[i] = wrap[i] && state_reg.ctl[i][CTL_WRAP_BIT];
      if (i == 0) begin : g_fixed
         // Fixed counter ignores event selection and shaping
         assign raw_inc[i] = INC_W'(dclk_tick);
         assign thresh[i] = '0;
         assign edge_on[i] = 1'b0;
      end else begin : g_gen
         assign raw_inc[i] = event_inc[i-1];
         assign thresh[i] = state_reg.ctl[i][THRESH_LSB+:FIELD_W];
         assign edge_on[i] = state_reg.ctl[i][CTL_EDGE_BIT];
         // Source returns the increment of the event and subevents chosen here
         assign event_choice[i-1] = state_reg.ctl[i][EVSEL_LSB+:FIELD_W];
         assign subevent_mask[i-1] = state_reg.ctl[i][UMASK_LSB+:FIELD_W];
      end
      event_shaper u_shaper (
         .clk(clk),
         .reset_n(reset_n),
         .raw_inc(raw_inc[i]),
         .thresh(thresh[i]),
         .edge_on(edge_on[i]),
         .inc(shaped[i])
      );
      wrap_counter u_counter (
         .clk(clk),
         .reset_n(reset_n),
         .count_en(ctr_en[i]),
         .inc(shaped[i]),
         .clr(ctr_clr[i]),
         .load_lo(wr_lo[i]),
         .load_hi(wr_hi[i]),
         .wdata(cfg_wdata),
         .count(count[i]),
         .wrap(wrap[i])
      );
   end

   // Read mux; box control reads as zero, its stored freeze bit included
   always_comb begin
      rd_val = '0;
      if (cfg_addr == OFS_BOX_STATUS) begin
         rd_val = DATA_W'(state_reg.wrap_flags);
      end
      for (int i = 0; i < NUM_CTR; i++) begin
         if (cfg_addr == ctl_addr(i)) begin
            rd_val = state_reg.ctl[i];
         end
         if (cfg_addr == ctr_addr(i)) begin
            rd_val = count[i][DATA_W-1:0];
         end
         if (cfg_addr == ctr_addr(i) + CTR_HI_STEP) begin
            rd_val = DATA_W'(count[i][CNT_W-1:DATA_W]);
         end
      end
   end

   // Next state; a wrap in the clearing cycle keeps its flag set
   always_comb begin
      state_next = state_reg;
      state_next.rvalid = 1'b0;
      state_next.msg = 1'b0;
      if (wr_box) begin
         state_next.frozen = cfg_wdata[BOX_FRZ_BIT];
      end
      for (int i = 0; i < NUM_CTR; i++) begin
         if (wr_ctl[i]) begin
            state_next.ctl[i] = cfg_wdata & ((i == 0) ? FIXED_KEEP_MASK : CTL_KEEP_MASK);
         end
      end
      if (box_clr_ctls) begin
         state_next.ctl = '0;
      end
      if (wr_stat) begin
         state_next.wrap_flags = state_reg.wrap_flags & ~cfg_wdata[NUM_CTR-1:0];
      end
      state_next.wrap_flags = state_next.wrap_flags | flag_set;
      state_next.msg = |flag_set;
      if (cfg_rd) begin
         state_next.rvalid = 1'b1;
         state_next.rdata = rd_val;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg.ctl <= {NUM_CTR{CTL_RESET}};
         state_reg.wrap_flags <= FLAGS_RESET;
         state_reg.frozen <= 1'b0;
         state_reg.rdata <= RDATA_RESET;
         state_reg.rvalid <= 1'b0;
         state_reg.msg <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flops
   assign cfg_rdata = state_reg.rdata;
   assign cfg_rvalid = state_reg.rvalid;
   assign global_monitor_unit_wrap = state_reg.msg;
   assign box_frozen = state_reg.frozen;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Writes may clear or preload a counter, so the counting checks leave them out
   logic any_wr;
   assign any_wr = cfg_wr;

   freeze_stops_a: assert property (
      box_frozen && !any_wr |=> $stable(count[1]) && $stable(count[0]))
      else $error("frozen counter moved");
   clear_counts_a: assert property (
      box_clr_ctrs |=> (count[0] == '0) && (count[1] == '0) && (count[4] == '0))
      else $error("clear-all-counts left a counter non-zero");
   clear_selects_a: assert property (
      box_clr_ctls |=> (state_reg.ctl == '0) && (event_choice == '0))
      else $error("clear-all-selects left a control bit set");
   flag_sticky_a: assert property (
      state_reg.wrap_flags[1] && !(wr_stat && cfg_wdata[1]) |=> state_reg.wrap_flags[1])
      else $error("wrap flag dropped without a one written");
   flag_clear_a: assert property (
      wr_stat && cfg_wdata[1] && !flag_set[1] |=> !state_reg.wrap_flags[1])
      else $error("wrap flag not cleared by a one");
   wrap_report_a: assert property (
      flag_set[1] |=> state_reg.wrap_flags[1] && global_monitor_unit_wrap)
      else $error("reported wrap not flagged or messaged");
   msg_cause_a: assert property (
      global_monitor_unit_wrap |-> $past(|flag_set))
      else $error("wrap message without a reported wrap");
   choice_out_a: assert property (
      wr_ctl[1] && !box_clr_ctls |=> event_choice[0] == $past(cfg_wdata[EVSEL_LSB+:FIELD_W]))
      else $error("event choice not taken from write");
   mask_out_a: assert property (
      wr_ctl[2] && !box_clr_ctls |=> subevent_mask[1] == $past(cfg_wdata[UMASK_LSB+:FIELD_W]))
      else $error("subevent mask not taken from write");
   thresh_level_a: assert property (
      thresh[2] != '0 && !edge_on[2] |-> shaped[2] == INC_W'(raw_inc[2] >= thresh[2]))
      else $error("threshold compare wrong");
   edge_single_a: assert property (
      thresh[3] != '0 && edge_on[3] && shaped[3] != '0 && !wr_ctl[3] && !wr_box
         |=> shaped[3] == '0)
      else $error("edge detect counted twice in a row");
   ctr_clear_a: assert property (
      wr_ctl[1] && cfg_wdata[CTL_RST_BIT] |=> count[1] == '0)
      else $error("counter clear missed");
   enable_gate_a: assert property (
      !state_reg.ctl[1][CTL_EN_BIT] && !any_wr |=> $stable(count[1]))
      else $error("disabled counter moved");
   wrap_around_a: assert property (
      wrap[1] && !any_wr |=> count[1] < $past(count[1]))
      else $error("counter did not wrap");
   fixed_tick_a: assert property (
      ctr_en[0] && dclk_tick && !any_wr |=> count[0] == $past(count[0]) + CNT_W'(1))
      else $error("fixed counter missed a DRAM clock");
   read_zero_a: assert property (
      cfg_rd && cfg_addr == OFS_BOX_CTL |=> cfg_rvalid && cfg_rdata == '0)
      else $error("box control did not read zero");

   // Box control, status and reporting
   freeze_set_a: assert property (
      wr_box && cfg_wdata[BOX_FRZ_BIT] |=> box_frozen)
      else $error("freeze bit did not freeze the box");
   unfreeze_a: assert property (
      wr_box && !cfg_wdata[BOX_FRZ_BIT] |=> !box_frozen)
      else $error("box stayed frozen after a write without freeze");
   frozen_hold_a: assert property (
      box_frozen && !wr_box |=> box_frozen)
      else $error("freeze dropped without a box write");
   clear_gen_a: assert property (
      box_clr_ctrs |=> (count[2] == '0) && (count[3] == '0))
      else $error("clear-all-counts left a generic counter non-zero");
   unreported_wrap_a: assert property (
      wrap[2] && !state_reg.ctl[2][CTL_WRAP_BIT] && !state_reg.wrap_flags[2]
         |=> !state_reg.wrap_flags[2])
      else $error("unreported wrap set its flag");

   // Field outputs, shaping and counting
   choice_stable_a: assert property (
      !wr_ctl[1] && !box_clr_ctls |=> $stable(event_choice[0]))
      else $error("event choice moved without a write");
   raw_add_a: assert property (
      thresh[1] == '0 |-> shaped[1] == raw_inc[1])
      else $error("zero threshold did not add the raw increment");
   edge_rise_a: assert property (
      thresh[3] != '0 && edge_on[3] && raw_inc[3] >= thresh[3]
         && $past(raw_inc[3] < thresh[3]) |-> shaped[3] == INC_W'(1))
      else $error("edge detect missed a rising transition");
   count_step_a: assert property (
      ctr_en[1] && !any_wr |=> count[1] == $past(count[1]) + CNT_W'($past(shaped[1])))
      else $error("enabled counter did not add its shaped increment");
   preload_lo_a: assert property (
      wr_lo[1] |=> count[1][DATA_W-1:0] == $past(cfg_wdata))
      else $error("low word preload missed");
   preload_hi_a: assert property (
      wr_hi[1] |=> count[1][CNT_W-1:DATA_W] == $past(cfg_wdata[CNT_W-DATA_W-1:0]))
      else $error("high word preload missed");

   // Register reads; action and reserved bits must come back as zero
   status_read_a: assert property (
      cfg_rd && cfg_addr == OFS_BOX_STATUS |=> cfg_rdata == DATA_W'($past(state_reg.wrap_flags)))
      else $error("status read did not show the wrap flags");
   ctl_read_a: assert property (
      cfg_rd && cfg_addr == ctl_addr(1) |=> (cfg_rdata & ~CTL_KEEP_MASK) == '0)
      else $error("control read showed an action or reserved bit");
   fixed_read_a: assert property (
      cfg_rd && cfg_addr == OFS_FIXED_CTL |=> (cfg_rdata & ~FIXED_KEEP_MASK) == '0)
      else $error("fixed control read showed an action or reserved bit");
   hi_read_a: assert property (
      cfg_rd && cfg_addr == ctr_addr(1) + CTR_HI_STEP |=> cfg_rdata[DATA_W-1:CNT_W-DATA_W] == '0)
      else $error("high counter word showed bits above 47");

   // Main scenarios; the race cover shows a wrap meeting a clear of its own flag
   wrap_seen_c: cover property (global_monitor_unit_wrap);
   edge_count_c: cover property (edge_on[3] && shaped[3] != '0);
   freeze_c: cover property (box_frozen && ctr_en == '0 ##1 !box_frozen);
   w1c_race_c: cover property (wr_stat && |(cfg_wdata[NUM_CTR-1:0] & flag_set));
   quiet_wrap_c: cover property (wrap[2] && !flag_set[2]);
endmodule : chan_pmon_box

/* File: dv/global_monitor_model.sv */
// Behavioural model of the socket-wide unit that gathers box wrap messages
module global_monitor_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Box side
   input wire logic wrap_msg,
   // Software side
   input wire logic summary_clr,
   output logic box_wrap_summary
);
   timeunit 1ns;
   timeprecision 100ps;
   // A message wins over a clear in the same cycle so that no wrap is ever lost
   always @(posedge clk) begin
      if (!reset_n) begin
         box_wrap_summary <= 1'b0;
      end else if (wrap_msg === 1'b1) begin
         box_wrap_summary <= 1'b1;
      end else if (summary_clr) begin
         box_wrap_summary <= 1'b0;
      end
   end
endmodule : global_monitor_model

/* File: dv/tb.sv */
// Self-checking bench for the channel monitoring box and its global partner
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import pmon_pkg::*;
   logic clk;
   logic reset_n;
   logic cfg_wr;
   logic cfg_rd;
   logic [ADDR_W-1:0] cfg_addr;
   logic [DATA_W-1:0] cfg_wdata;
   logic [DATA_W-1:0] cfg_rdata;
   logic cfg_rvalid;
   logic dclk_tick;
   logic [NUM_GEN-1:0][INC_W-1:0] event_inc;
   logic [NUM_GEN-1:0][FIELD_W-1:0] event_choice;
   logic [NUM_GEN-1:0][FIELD_W-1:0] subevent_mask;
   logic global_monitor_unit_wrap;
   logic box_frozen;
   logic summary_clr;
   logic box_wrap_summary;
   logic [31:0] exp_q[$];
   logic [47:0] exp_cnt [NUM_CTR];
   logic [31:0] ctlv [NUM_GEN];
   logic [7:0] thr [NUM_GEN] = '{8'h00, 8'h04, 8'h01, 8'h02};
   logic edg [NUM_GEN] = '{1'b0, 1'b0, 1'b1, 1'b1};
   logic prev_q [NUM_GEN];
   logic [31:0] seed = 32'h3122d1cb;
   int fails = 0;
   int checks_done = 0;
   int pulses = 0;

   chan_pmon_box u_dut (.clk(clk), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid), .dclk_tick(dclk_tick), .event_inc(event_inc),
      .event_choice(event_choice), .subevent_mask(subevent_mask),
      .global_monitor_unit_wrap(global_monitor_unit_wrap), .box_frozen(box_frozen));
   global_monitor_model u_gmu (.clk(clk), .reset_n(reset_n),
      .wrap_msg(global_monitor_unit_wrap), .summary_clr(summary_clr),
      .box_wrap_summary(box_wrap_summary));

   // Free-running 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xorshift

   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic print_verdict();
      if (fails == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // Single-cycle strobes with an idle cycle after each, so a strobe is never set twice
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge clk);
      cfg_rd <= 1'b0;
      exp_q.push_back(e);
   endtask : rd

   // Both words of every counter; the upper half of the high word is unused
   task automatic rd_all();
      for (int s = 0; s < NUM_CTR; s++) begin
         rd(ctr_addr(s), exp_cnt[s][31:0]);
         rd(ctr_addr(s) + 8'h04, {16'h0000, exp_cnt[s][47:32]});
      end
   endtask : rd_all

   // Random events; the model counts only when live, mirroring the shaper per counter
   task automatic burst(input int n, input logic live);
      logic [7:0] v;
      logic q;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         seed = xorshift(seed);
         dclk_tick <= seed[20];
         if (live) exp_cnt[0] += 48'(seed[20]);
         for (int k = 0; k < NUM_GEN; k++) begin
            v = 8'(seed[k*4 +: 3]);
            event_inc[k] <= v;
            q = (v >= thr[k]);
            if (!live) begin
               prev_q[k] = q;
            end else if (thr[k] == 8'h00) begin
               exp_cnt[k+1] += 48'(v);
            end else begin
               exp_cnt[k+1] += 48'(q && !(edg[k] && prev_q[k]));
            end
            prev_q[k] = q;
         end
      end
      @(posedge clk);
      event_inc <= '0;
      dclk_tick <= 1'b0;
      prev_q = '{default: 1'b0};
      repeat (3) @(posedge clk);
   endtask : burst

   // Read answers are matched in order against the notes of the driver
   always @(posedge clk) begin
      if (cfg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) chk("unrequested answer", 48'h0, 48'h1);
         else chk("cfg_rdata", 48'(exp_q.pop_front()), 48'(cfg_rdata));
      end
      if (global_monitor_unit_wrap === 1'b1) pulses++;
   end

   // Hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      print_verdict();
   end

   initial begin
      reset_n = 1'b0;
      {cfg_wr, cfg_rd, dclk_tick, summary_clr} = 4'h0;
      cfg_addr = '0;
      cfg_wdata = '0;
      event_inc = '0;
      exp_cnt = '{default: 48'h0};
      prev_q = '{default: 1'b0};
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      // Reset state, write-only box bits and an unmapped place
      rd(OFS_BOX_STATUS, 32'h0);
      rd(OFS_BOX_CTL, 32'h0);
      rd(8'h00, 32'h0);
      for (int s = 0; s < NUM_CTR; s++) rd(ctl_addr(s), 32'h0);
      rd_all();
      // Enabled controls with random event and subevent choices
      for (int k = 0; k < NUM_GEN; k++) begin
         seed = xorshift(seed);
         ctlv[k] = {thr[k], 4'b0100, 1'b0, edg[k], 2'b00, seed[15:0]};
         wr(ctl_addr(k + 1), ctlv[k]);
         @(negedge clk);
         chk("event_choice", 48'(ctlv[k][7:0]), 48'(event_choice[k]));
         chk("subevent_mask", 48'(ctlv[k][15:8]), 48'(subevent_mask[k]));
         rd(ctl_addr(k + 1), ctlv[k]);
      end
      wr(OFS_FIXED_CTL, 32'h00400000);
      burst(40, 1'b1);
      rd_all();
      // Frozen box ignores all events
      wr(OFS_BOX_CTL, 32'h00030100);
      @(negedge clk);
      chk("box_frozen", 48'h1, 48'(box_frozen));
      rd(OFS_BOX_CTL, 32'h0);
      burst(20, 1'b0);
      rd_all();
      wr(OFS_BOX_CTL, 32'h00030000);
      @(negedge clk);
      chk("box_frozen", 48'h0, 48'(box_frozen));
      // One counter cleared through its own control word
      wr(ctl_addr(1), ctlv[0] | 32'h00020000);
      exp_cnt[1] = 48'h0;
      rd(ctl_addr(1), ctlv[0]);
      rd_all();
      wr(OFS_BOX_CTL, 32'h00030002);
      exp_cnt = '{default: 48'h0};
      rd_all();
      // Preload near the top, then wrap the fixed and two generic counters
      for (int s = 0; s < 3; s++) begin
         wr(ctr_addr(s), 32'hffffffff);
         wr(ctr_addr(s) + 8'h04, 32'h0000ffff);
      end
      wr(ctl_addr(1), 32'h00500000);
      wr(ctl_addr(2), 32'h00400000);
      wr(OFS_FIXED_CTL, 32'h00500000);
      chk("messages before wrap", 48'h0, 48'(pulses));
      @(posedge clk);
      event_inc <= {8'h00, 8'h00, 8'h01, 8'h01};
      dclk_tick <= 1'b1;
      repeat (3) @(posedge clk);
      event_inc <= '0;
      dclk_tick <= 1'b0;
      repeat (3) @(posedge clk);
      for (int s = 0; s < 3; s++) exp_cnt[s] = 48'h2;
      rd_all();
      rd(OFS_BOX_STATUS, 32'h3);
      chk("messages sent", 48'h1, 48'(pulses));
      chk("box_wrap_summary", 48'h1, 48'(box_wrap_summary));
      wr(OFS_BOX_STATUS, 32'h0);
      rd(OFS_BOX_STATUS, 32'h3);
      wr(OFS_BOX_STATUS, 32'h2);
      rd(OFS_BOX_STATUS, 32'h1);
      wr(OFS_BOX_STATUS, 32'h1);
      rd(OFS_BOX_STATUS, 32'h0);
      @(posedge clk);
      summary_clr <= 1'b1;
      @(posedge clk);
      summary_clr <= 1'b0;
      // Clear-all-selects returns every control word to zero
      wr(OFS_BOX_CTL, 32'h00030001);
      @(negedge clk);
      chk("event_choice", 48'h0, 48'(event_choice));
      for (int s = 0; s < NUM_CTR; s++) rd(ctl_addr(s), 32'h0);
      repeat (4) @(posedge clk);
      chk("box_wrap_summary", 48'h0, 48'(box_wrap_summary));
      chk("pending reads", 48'h0, 48'(exp_q.size()));
      print_verdict();
   end
endmodule : tb
